// file: hdl/debug_unit_defines.vh
`ifndef DEBUG_UNIT_DEFINES_VH
`define DEBUG_UNIT_DEFINES_VH
// register byte offsets
`define DEBUG_UNIT_CTRL_OFS 8'h00
`define DEBUG_UNIT_MODE_OFS 8'h04
`define DEBUG_UNIT_STAT_OFS 8'h14
`define RECEIVE_HOLDING_REGISTER_OFS 8'h18
`define DEBUG_UNIT_THR_OFS 8'h1c
`define DEBUG_UNIT_BAUD_OFS 8'h20
`define DEBUG_UNIT_EMU_OFS 8'h48
// control bits
`define UART_CONTROL_REGISTER_RST_RX 2
`define UART_CONTROL_REGISTER_RX_EN 4
`define UART_CONTROL_REGISTER_RX_DIS 5
`define UART_CONTROL_REGISTER_RST_TX 3
`define UART_CONTROL_REGISTER_TX_EN 6
`define UART_CONTROL_REGISTER_TX_DIS 7
`define UART_CONTROL_REGISTER_STA_CLR 8
// mode fields
`define UART_MODE_REGISTER_PAR_LSB 9
`define UART_MODE_REGISTER_PAR_MSB 11
`define UART_MODE_REGISTER_CHM_LSB 14
`define UART_MODE_REGISTER_CHM_MSB 15
// parity codes
`define DEBUG_UNIT_PAR_EVEN 3'h0
`define DEBUG_UNIT_PAR_ODD 3'h1
`define DEBUG_UNIT_PAR_SPACE 3'h2
`define DEBUG_UNIT_PAR_MARK 3'h3
// channel modes
`define DEBUG_UNIT_CHM_NORMAL 2'h0
`define DEBUG_UNIT_CHM_ECHO 2'h1
`define DEBUG_UNIT_CHM_LOCAL 2'h2
`define DEBUG_UNIT_CHM_REMOTE 2'h3
// status bits
`define UART_STATUS_REGISTER_RECEIVE_READY_FLAG 0
`define UART_STATUS_REGISTER_TXRDY 1
`define UART_STATUS_REGISTER_OVR 5
`define UART_STATUS_REGISTER_FRM 6
`define UART_STATUS_REGISTER_PAR 7
`define UART_STATUS_REGISTER_TXEMPTY 9
`define UART_STATUS_REGISTER_DCC_RD 30
`define UART_STATUS_REGISTER_DCC_WR 31
// timing, in sampling ticks
`define DEBUG_UNIT_OVERSAMPLE 16
`define DEBUG_UNIT_START_MIN 7
`define DEBUG_UNIT_FIRST_SAMPLE 24
`define DEBUG_UNIT_BIT_TICKS 16
`endif

// file: hdl/debug_unit_sync2.v
`timescale 1ns/1ps
// two-flop level synchroniser; first stage read only by the second
module debug_unit_sync2 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  pclk,
  presetn,
  d,
  q
);
  input wire pclk;
  input wire presetn;
  input wire [W-1:0] d;
  output reg [W-1:0] q;
  reg [W-1:0] meta_ff;

  // resets to the idle level of the line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= INIT;
      q <= INIT;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // debug_unit_sync2

// file: hdl/debug_unit_uart.v
// Behaviour
// R1: baud clock is master clock over sixteen times divisor, shared by rx and tx
// R2: divisor zero stops baud clock, whole uart inactive
// R3: divisor field is 16 bits, rates from clk/16 down to clk/(16*65535)
// R4: async only, 8-bit chars, optional parity, no clock pin, no timeout
// R5: receiver and transmitter independent, common baud generator
// R6: receiver disabled at reset; enable command starts start-bit search
// R7: disable stops at once when idle, else after the stop bit
// R8: receiver reset aborts reception, drops partial char, disables
// R9: start accepted after line low more than 7 sampling ticks
// R10: first sample 24 ticks after falling edge, then every 16
// R11: full char goes to holding register and sets receive ready
// R12: reading holding register clears receive ready
// R13: char completing with receive ready set raises overrun
// R14: overrun cleared only by status clear command
// R15: parity checked per type; mismatch sets parity error with ready
// R16: parity error sticky until status clear command
// R17: parity types even, odd, mark, space for tx and rx
// R18: normal, echo, local loopback and remote loopback modes
// R19: transfer-channel requests for receiver and transmitter
// R20: debug channel full flags visible in status, raise interrupt
// R21: software can force emulator test reset to block access
// R22: stop bit zero sets stop-bit error with ready, sticky
// R23: tx sends start, 8 data lsb first, optional parity, stop
// R24: local loopback feeds tx to rx, line high; remote ties rx to tx
// R25: echo repeats rx pin on tx pin, transmitter still runs
// R26: stop sampled 16 ticks after last bit, then start search
// R27: sampling tick from counter reloaded with divisor on expiry
`timescale 1ns/1ps
`include "debug_unit_defines.vh"
module debug_unit_uart #(
  parameter DIV_W = 16
) (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  serial_receive_in,
  serial_transmit_out,
  debug_channel_read_full,
  debug_channel_write_full,
  rx_transfer_req,
  tx_transfer_req,
  debug_unit_irq,
  emulator_block_bit
);
  input wire pclk;
  input wire presetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [7:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  input wire serial_receive_in;
  output reg serial_transmit_out;
  input wire debug_channel_read_full;
  input wire debug_channel_write_full;
  output reg rx_transfer_req;
  output reg tx_transfer_req;
  output reg debug_unit_irq;
  output reg emulator_block_bit;

  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_OFF = 2'h3;
  localparam [4:0] T_FIRST = `DEBUG_UNIT_FIRST_SAMPLE;
  localparam [4:0] T_BIT = `DEBUG_UNIT_BIT_TICKS;
  localparam [3:0] T_START = `DEBUG_UNIT_START_MIN;

  // synchronised pins
  wire rxd_s;
  wire [1:0] dcc_s;
  debug_unit_sync2 #(.W(1), .INIT(1'b1)) u_rx_sync (
    .pclk(pclk), .presetn(presetn), .d(serial_receive_in), .q(rxd_s));
  debug_unit_sync2 #(.W(2), .INIT(2'h0)) u_dcc_sync (
    .pclk(pclk), .presetn(presetn),
    .d({debug_channel_write_full, debug_channel_read_full}), .q(dcc_s));

  reg [DIV_W-1:0] baud_divisor_ff; // R3
  reg [2:0] par_ff;
  reg [1:0] chm_ff;
  reg [DIV_W-1:0] div_cnt_ff;
  reg tick_ff;
  reg [1:0] rx_st_ff;
  reg rx_en_ff;
  reg rx_dis_pend_ff;
  reg [4:0] rx_cnt_ff;
  reg [3:0] rx_bit_ff;
  reg [8:0] rx_sh_ff;
  reg [7:0] rhr_ff;
  reg rdy_ff, ovr_ff, parity_error_flag_ff, frm_ff;
  reg tx_en_ff, tx_dis_pend_ff, thr_full_ff, tx_busy_ff;
  reg [7:0] thr_ff;
  reg [10:0] tx_sh_ff;
  reg [3:0] tx_bits_ff;
  reg [3:0] tx_tick_ff;
  reg tx_line_ff;

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire cr_wr = wr_acc & (paddr == `DEBUG_UNIT_CTRL_OFS);
  wire rhr_rd = rd_acc & (paddr == `RECEIVE_HOLDING_REGISTER_OFS);
  wire thr_wr = wr_acc & (paddr == `DEBUG_UNIT_THR_OFS);
  wire uart_on = (baud_divisor_ff != {DIV_W{1'b0}}); // R2
  wire par_on = ~par_ff[2]; // codes 4..7 mean no parity
  wire [3:0] n_bits = par_on ? 4'h9 : 4'h8; // R4

  // parity of a byte for the selected type
  function par_of;
    input [7:0] d;
    input [2:0] t;
    begin
      case (t)
        `DEBUG_UNIT_PAR_EVEN: par_of = ^d;
        `DEBUG_UNIT_PAR_ODD: par_of = ~(^d);
        `DEBUG_UNIT_PAR_SPACE: par_of = 1'b0;
        `DEBUG_UNIT_PAR_MARK: par_of = 1'b1;
        default: par_of = 1'b0;
      endcase
    end
  endfunction

  // receiver input per channel mode; remote loopback disables the receiver
  wire rx_in = (chm_ff == `DEBUG_UNIT_CHM_LOCAL) ? tx_line_ff : rxd_s; // R24
  wire rx_live = uart_on & (chm_ff != `DEBUG_UNIT_CHM_REMOTE);

  // apb answers in the access cycle, no wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `DEBUG_UNIT_MODE_OFS: prdata <= {16'h0000, chm_ff, 2'h0, par_ff, 9'h000};
          `DEBUG_UNIT_STAT_OFS: prdata <= {dcc_s[1], dcc_s[0], 20'h00000, // R20
            ~thr_full_ff & ~tx_busy_ff & tx_en_ff, 1'b0, parity_error_flag_ff, frm_ff, ovr_ff,
            3'h0, ~thr_full_ff & tx_en_ff, rdy_ff};
          `RECEIVE_HOLDING_REGISTER_OFS: prdata <= {24'h000000, rhr_ff};
          `DEBUG_UNIT_BAUD_OFS: prdata <= {{(32-DIV_W){1'b0}}, baud_divisor_ff};
          `DEBUG_UNIT_EMU_OFS: prdata <= {31'h0000_0000, emulator_block_bit};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // unmapped reads give zero; apb pready is low in setup, so accesses pair

  // configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_divisor_ff <= {DIV_W{1'b0}};
      par_ff <= 3'h0;
      chm_ff <= 2'h0;
      emulator_block_bit <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == `DEBUG_UNIT_BAUD_OFS) baud_divisor_ff <= pwdata[DIV_W-1:0];
      if (paddr == `DEBUG_UNIT_MODE_OFS) begin
        par_ff <= pwdata[`UART_MODE_REGISTER_PAR_MSB:`UART_MODE_REGISTER_PAR_LSB]; // R17
        chm_ff <= pwdata[`UART_MODE_REGISTER_CHM_MSB:`UART_MODE_REGISTER_CHM_LSB]; // R18
      end
      if (paddr == `DEBUG_UNIT_EMU_OFS) emulator_block_bit <= pwdata[0]; // R21
    end
  end

  // sampling tick: reload divider with divisor on expiry
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= {DIV_W{1'b0}};
      tick_ff <= 1'b0;
    end else if (!uart_on) begin
      div_cnt_ff <= {DIV_W{1'b0}}; // R2
      tick_ff <= 1'b0;
    end else if (div_cnt_ff <= {{(DIV_W-1){1'b0}}, 1'b1}) begin
      div_cnt_ff <= baud_divisor_ff; // R27 R1
      tick_ff <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff - {{(DIV_W-1){1'b0}}, 1'b1};
      tick_ff <= 1'b0;
    end
  end

  // receiver state machine; tick is shared with the transmitter
  wire rx_done = tick_ff & (rx_st_ff == RX_DATA) & (rx_cnt_ff == 5'h01)
    & (rx_bit_ff == n_bits); // stop-bit sample
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_ff <= RX_OFF; // R6
      rx_en_ff <= 1'b0;
      rx_dis_pend_ff <= 1'b0;
      rx_cnt_ff <= 5'h00;
      rx_bit_ff <= 4'h0;
      rx_sh_ff <= 9'h000;
    end else if (cr_wr & pwdata[`UART_CONTROL_REGISTER_RST_RX]) begin
      rx_st_ff <= RX_OFF; // R8
      rx_en_ff <= 1'b0;
      rx_dis_pend_ff <= 1'b0;
    end else begin
      if (cr_wr & pwdata[`UART_CONTROL_REGISTER_RX_DIS]) begin
        if (rx_st_ff == RX_DATA) rx_dis_pend_ff <= 1'b1; // R7
        else begin
          rx_en_ff <= 1'b0;
          rx_st_ff <= RX_OFF;
        end
      end else if (cr_wr & pwdata[`UART_CONTROL_REGISTER_RX_EN] & ~rx_en_ff) begin
        rx_en_ff <= 1'b1; // R6
        rx_st_ff <= RX_IDLE;
      end else if (!rx_live) begin
        if (rx_st_ff != RX_OFF) rx_st_ff <= RX_IDLE;
      end else if (tick_ff) begin
        case (rx_st_ff)
          RX_IDLE: begin
            rx_cnt_ff <= 5'h00;
            if (!rx_in) rx_st_ff <= RX_START;
          end
          RX_START: begin
            if (rx_in) rx_st_ff <= RX_IDLE; // R9 glitch ignored
            else if (rx_cnt_ff[3:0] == T_START - 4'h1) begin
              rx_st_ff <= RX_DATA; // low for more than 7 ticks
              rx_cnt_ff <= T_FIRST - 5'h08 - 5'h01; // R10
              rx_bit_ff <= 4'h0;
            end else rx_cnt_ff <= rx_cnt_ff + 5'h01;
          end
          RX_DATA: begin
            if (rx_cnt_ff != 5'h01) rx_cnt_ff <= rx_cnt_ff - 5'h01;
            else begin
              rx_cnt_ff <= T_BIT; // R10 R26
              if (rx_bit_ff != n_bits) begin
                rx_sh_ff[rx_bit_ff] <= rx_in;
                rx_bit_ff <= rx_bit_ff + 4'h1;
              end else begin
                rx_st_ff <= rx_dis_pend_ff ? RX_OFF : RX_IDLE; // R26 R7
                rx_en_ff <= ~rx_dis_pend_ff;
                rx_dis_pend_ff <= 1'b0;
              end
            end
          end
          default: rx_st_ff <= RX_OFF;
        endcase
      end
    end
  end
  // start detect counts on the tick after the low is seen, so total > 7

  // holding register and flags; events win over clears
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rhr_ff <= 8'h00;
      rdy_ff <= 1'b0;
      ovr_ff <= 1'b0;
      parity_error_flag_ff <= 1'b0;
      frm_ff <= 1'b0;
    end else begin
      if (rx_done) begin
        rhr_ff <= rx_sh_ff[7:0]; // R11
        rdy_ff <= 1'b1; // R11
        if (rdy_ff & ~rhr_rd) ovr_ff <= 1'b1; // R13
        if (par_on & (rx_sh_ff[8] != par_of(rx_sh_ff[7:0], par_ff)))
          parity_error_flag_ff <= 1'b1; // R15 R16
        if (!rx_in) frm_ff <= 1'b1; // R22
      end else if (rhr_rd) rdy_ff <= 1'b0; // R12
      if (cr_wr & pwdata[`UART_CONTROL_REGISTER_STA_CLR] & ~rx_done) begin
        ovr_ff <= 1'b0; // R14
        parity_error_flag_ff <= 1'b0; // R16
        frm_ff <= 1'b0; // R22
      end
    end
  end

  // transmitter: holding register, shift register and bit timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_ff <= 1'b0;
      tx_dis_pend_ff <= 1'b0;
      thr_full_ff <= 1'b0;
      thr_ff <= 8'h00;
      tx_busy_ff <= 1'b0;
      tx_sh_ff <= 11'h7ff;
      tx_bits_ff <= 4'h0;
      tx_tick_ff <= 4'h0;
    end else if (cr_wr & pwdata[`UART_CONTROL_REGISTER_RST_TX]) begin
      tx_en_ff <= 1'b0;
      tx_dis_pend_ff <= 1'b0;
      thr_full_ff <= 1'b0;
      tx_busy_ff <= 1'b0;
      tx_sh_ff <= 11'h7ff;
    end else begin
      if (cr_wr & pwdata[`UART_CONTROL_REGISTER_TX_EN]) tx_en_ff <= 1'b1;
      if (cr_wr & pwdata[`UART_CONTROL_REGISTER_TX_DIS]) begin
        if (tx_busy_ff | thr_full_ff) tx_dis_pend_ff <= 1'b1;
        else tx_en_ff <= 1'b0;
      end
      if (thr_wr & tx_en_ff) begin
        thr_ff <= pwdata[7:0];
        thr_full_ff <= 1'b1;
      end
      if (tx_dis_pend_ff & ~tx_busy_ff & ~thr_full_ff) begin
        tx_en_ff <= 1'b0;
        tx_dis_pend_ff <= 1'b0;
      end
      if (!tx_busy_ff & thr_full_ff & uart_on) begin
        // frame: stop, parity, data lsb first, start
        tx_sh_ff <= par_on ? {1'b1, par_of(thr_ff, par_ff), thr_ff, 1'b0} // R23
                           : {2'h3, thr_ff, 1'b0};
        tx_bits_ff <= n_bits + 4'h2;
        tx_tick_ff <= 4'h0;
        tx_busy_ff <= 1'b1;
        if (!(thr_wr & tx_en_ff)) thr_full_ff <= 1'b0;
      end else if (tx_busy_ff & tick_ff) begin
        tx_tick_ff <= tx_tick_ff + 4'h1;
        if (tx_tick_ff == 4'hf) begin
          tx_sh_ff <= {1'b1, tx_sh_ff[10:1]}; // R1 one bit per 16 ticks
          tx_bits_ff <= tx_bits_ff - 4'h1;
          if (tx_bits_ff == 4'h1) tx_busy_ff <= 1'b0;
        end
      end
    end
  end

  // transmitter line, idle high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_line_ff <= 1'b1;
    else tx_line_ff <= tx_busy_ff ? tx_sh_ff[0] : 1'b1; // R5
  end

  // pin mux per channel mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) serial_transmit_out <= 1'b1;
    else begin
      case (chm_ff)
        `DEBUG_UNIT_CHM_NORMAL: serial_transmit_out <= tx_line_ff;
        `DEBUG_UNIT_CHM_ECHO: serial_transmit_out <= rxd_s; // R25
        `DEBUG_UNIT_CHM_LOCAL: serial_transmit_out <= 1'b1; // R24
        `DEBUG_UNIT_CHM_REMOTE: serial_transmit_out <= rxd_s; // R24
        default: serial_transmit_out <= 1'b1;
      endcase
    end
  end

  // transfer requests and interrupt line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_transfer_req <= 1'b0;
      tx_transfer_req <= 1'b0;
      debug_unit_irq <= 1'b0;
    end else begin
      rx_transfer_req <= rdy_ff & ~rhr_rd; // R19
      tx_transfer_req <= tx_en_ff & ~thr_full_ff & ~thr_wr; // R19
      debug_unit_irq <= dcc_s[0] | dcc_s[1]; // R20
    end
  end
endmodule // debug_unit_uart

// file: tb/duur_props.sv
`timescale 1ns/1ps
`include "debug_unit_defines.vh"
module duur_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire serial_receive_in,
  input wire serial_transmit_out,
  input wire debug_channel_read_full,
  input wire debug_channel_write_full,
  input wire rx_transfer_req,
  input wire debug_unit_irq,
  input wire emulator_block_bit
);
  logic [1:0] chm_ff;
  logic div0_ff;
  wire acc = psel && penable && pready;
  // shadow of channel mode and zero divisor, so pin checks know the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chm_ff <= 2'h0;
      div0_ff <= 1'b1;
    end else if (acc && pwrite && paddr == `DEBUG_UNIT_MODE_OFS) begin
      chm_ff <= pwdata[`UART_MODE_REGISTER_CHM_MSB:`UART_MODE_REGISTER_CHM_LSB];
    end else if (acc && pwrite && paddr == `DEBUG_UNIT_BAUD_OFS) begin
      div0_ff <= pwdata[15:0] == 16'h0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_local;
    (chm_ff == `DEBUG_UNIT_CHM_LOCAL)[*3];
  endsequence
  property p_answer;
    s_setup |=> pready && !pslverr;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer in access cycle");
  property p_emu;
    acc && pwrite && paddr == `DEBUG_UNIT_EMU_OFS |=> emulator_block_bit == $past(pwdata[0]);
  endproperty
  a_emu: assert property (p_emu) else $error("emulator block bit wrong");
  property p_irq;
    ($stable(debug_channel_read_full) && $stable(debug_channel_write_full))[*4] |->
      debug_unit_irq == (debug_channel_read_full || debug_channel_write_full);
  endproperty
  a_irq: assert property (p_irq) else $error("debug irq wrong");
  property p_rdclr;
    acc && !pwrite && paddr == `RECEIVE_HOLDING_REGISTER_OFS |-> ##2 !rx_transfer_req;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("ready kept after read");
  property p_local;
    s_local |-> serial_transmit_out;
  endproperty
  a_local: assert property (p_local) else $error("tx low in local loop");
  property p_remote;
    (chm_ff == `DEBUG_UNIT_CHM_REMOTE && $stable(serial_receive_in))[*5] |->
      serial_transmit_out == serial_receive_in;
  endproperty
  a_remote: assert property (p_remote) else $error("remote loop broken");
  property p_echo;
    (chm_ff == `DEBUG_UNIT_CHM_ECHO && $stable(serial_receive_in))[*5] |->
      serial_transmit_out == serial_receive_in;
  endproperty
  a_echo: assert property (p_echo) else $error("echo broken");
  property p_div0;
    (div0_ff && chm_ff == `DEBUG_UNIT_CHM_NORMAL)[*4] |-> serial_transmit_out;
  endproperty
  a_div0: assert property (p_div0) else $error("tx active with zero divisor");
endmodule // duur_props
bind debug_unit_uart duur_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .serial_receive_in(serial_receive_in),
  .serial_transmit_out(serial_transmit_out),
  .debug_channel_read_full(debug_channel_read_full),
  .debug_channel_write_full(debug_channel_write_full),
  .rx_transfer_req(rx_transfer_req), .debug_unit_irq(debug_unit_irq),
  .emulator_block_bit(emulator_block_bit));

// file: tb/duur_term.sv
`timescale 1ns/1ps
// remote terminal on the serial pins; line idles high
module duur_term #(
  parameter int BIT_CLKS = 16
) (
  input wire pclk,
  output logic line_out,
  input wire line_in
);
  initial line_out = 1'b1;
  // start, 8 data lsb first, optional parity, stop
  task automatic send(input logic [7:0] v, input logic up, input logic pb, input logic sb);
    logic q[$];
    q = {1'b0};
    for (int i = 0; i < 8; i++) q.push_back(v[i]);
    if (up) q.push_back(pb);
    q.push_back(sb);
    foreach (q[i]) begin
      line_out <= q[i];
      repeat (BIT_CLKS) @(posedge pclk);
    end
    line_out <= 1'b1;
  endtask
  // short low pulse, then a quiet gap long enough for any frame
  task automatic glitch(input int n);
    line_out <= 1'b0;
    repeat (n) @(posedge pclk);
    line_out <= 1'b1;
    repeat (200) @(posedge pclk);
  endtask
  // mid-bit capture of one unparitied frame; ok reports the stop level
  task automatic get(output logic [7:0] v, output logic ok);
    int n;
    n = 0;
    v = 8'h0;
    ok = 1'b0;
    while (line_in !== 1'b0 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge pclk);
      v[i] = line_in;
    end
    repeat (BIT_CLKS) @(posedge pclk);
    ok = line_in;
  endtask
endmodule // duur_term

// file: tb/tb_debug_unit_uart_receiver.sv
`timescale 1ns/1ps
`include "debug_unit_defines.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_debug_unit_uart_receiver;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic dcc_rd = 1'b0;
  logic dcc_wr = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic [7:0] d;
  logic pready, rxd, txd, rx_req, tx_req, emu, irq, ok;
  int num_checks = 0;
  int n_fail = 0;
  debug_unit_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .serial_receive_in(rxd), .serial_transmit_out(txd),
    .debug_channel_read_full(dcc_rd), .debug_channel_write_full(dcc_wr),
    .rx_transfer_req(rx_req), .tx_transfer_req(tx_req), .debug_unit_irq(irq),
    .emulator_block_bit(emu));
  duur_term #(.BIT_CLKS(16)) term (.pclk(pclk), .line_out(rxd), .line_in(txd));
  initial forever #2.5 pclk = ~pclk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one apb transfer, entered just after an edge; an extra edge keeps drives apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    @(posedge pclk);
  endtask
  task automatic ctl(input int b);
    apb(1'b1, `DEBUG_UNIT_CTRL_OFS, 32'h1 << b);
  endtask
  task automatic mode(input logic [2:0] p, input logic [1:0] c);
    apb(1'b1, `DEBUG_UNIT_MODE_OFS, (32'(c) << `UART_MODE_REGISTER_CHM_LSB) | (32'(p) << `UART_MODE_REGISTER_PAR_LSB));
  endtask
  // parity bit a correct sender would put on the line
  function automatic logic pbit(input logic [2:0] t, input logic [7:0] v);
    case (t)
      `DEBUG_UNIT_PAR_EVEN: return ^v;
      `DEBUG_UNIT_PAR_ODD: return ~^v;
      `DEBUG_UNIT_PAR_MARK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic rx_one(input logic [2:0] t, input logic [7:0] v, input logic bad, input logic sb);
    term.send(v, t < 3'h4, pbit(t, v) ^ bad, sb);
  endtask
  // bounded wait for the receive request level
  task automatic wait_rdy();
    int n;
    n = 0;
    while (rx_req !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (rx_req !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `DEBUG_UNIT_BAUD_OFS, 32'h0);
    `CHK("baud reset", 32'h0, rv)
    apb(1'b1, `DEBUG_UNIT_BAUD_OFS, 32'h1);
    rx_one(3'h0, 8'h5a, 1'b0, 1'b1);
    `CHK("rx off at reset", 1'b0, rx_req)
    ctl(`UART_CONTROL_REGISTER_RX_EN);
    apb(1'b1, `DEBUG_UNIT_BAUD_OFS, 32'h0);
    rx_one(3'h0, 8'h5b, 1'b0, 1'b1);
    `CHK("zero divisor idle", 1'b0, rx_req)
    apb(1'b1, `DEBUG_UNIT_BAUD_OFS, 32'h1);
    $display("test enable done");
    // every parity type, then no parity
    for (int t = 0; t < 5; t++) begin
      mode(3'(t), `DEBUG_UNIT_CHM_NORMAL);
      rx_one(3'(t), 8'h96 ^ 8'(t), 1'b0, 1'b1);
      wait_rdy();
      apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
      `CHK("par ok", 2'b01, {rv[`UART_STATUS_REGISTER_PAR], rv[`UART_STATUS_REGISTER_RECEIVE_READY_FLAG]})
      apb(1'b0, `RECEIVE_HOLDING_REGISTER_OFS, 32'h0);
      `CHK("rhr", 8'h96 ^ 8'(t), rv[7:0])
      apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
      `CHK("ready cleared", 1'b0, rv[`UART_STATUS_REGISTER_RECEIVE_READY_FLAG])
    end
    $display("test parity types done");
    mode(`DEBUG_UNIT_PAR_EVEN, `DEBUG_UNIT_CHM_NORMAL);
    rx_one(3'h0, 8'h31, 1'b1, 1'b1);
    wait_rdy();
    apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
    `CHK("par err", 1'b1, rv[`UART_STATUS_REGISTER_PAR])
    apb(1'b0, `RECEIVE_HOLDING_REGISTER_OFS, 32'h0);
    rx_one(3'h0, 8'h32, 1'b0, 1'b1);
    wait_rdy();
    apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
    `CHK("par sticky", 1'b1, rv[`UART_STATUS_REGISTER_PAR])
    ctl(`UART_CONTROL_REGISTER_STA_CLR);
    apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
    `CHK("par cleared", 1'b0, rv[`UART_STATUS_REGISTER_PAR])
    // 8'h32 still unread: the next char overruns
    rx_one(3'h0, 8'h33, 1'b0, 1'b1);
    apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
    `CHK("overrun", 1'b1, rv[`UART_STATUS_REGISTER_OVR])
    apb(1'b0, `RECEIVE_HOLDING_REGISTER_OFS, 32'h0);
    `CHK("rhr newest", 8'h33, rv[7:0])
    apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
    `CHK("overrun kept on read", 1'b1, rv[`UART_STATUS_REGISTER_OVR])
    ctl(`UART_CONTROL_REGISTER_STA_CLR);
    apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
    `CHK("overrun cleared", 1'b0, rv[`UART_STATUS_REGISTER_OVR])
    $display("test errors done");
    // low stop bit; the tail may start a false frame, which the reset drops
    rx_one(3'h0, 8'h44, 1'b0, 1'b0);
    wait_rdy();
    apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
    `CHK("stop err", 2'b11, {rv[`UART_STATUS_REGISTER_FRM], rv[`UART_STATUS_REGISTER_RECEIVE_READY_FLAG]})
    apb(1'b0, `RECEIVE_HOLDING_REGISTER_OFS, 32'h0);
    apb(1'b1, `DEBUG_UNIT_CTRL_OFS, (32'h1 << `UART_CONTROL_REGISTER_RST_RX) | (32'h1 << `UART_CONTROL_REGISTER_STA_CLR));
    repeat (200) @(posedge pclk);
    apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
    `CHK("reset drops char", 2'b00, {rv[`UART_STATUS_REGISTER_FRM], rv[`UART_STATUS_REGISTER_RECEIVE_READY_FLAG]})
    rx_one(3'h0, 8'h45, 1'b0, 1'b1);
    `CHK("off after reset", 1'b0, rx_req)
    ctl(`UART_CONTROL_REGISTER_RX_EN);
    fork
      rx_one(3'h0, 8'h6c, 1'b0, 1'b1);
      begin
        repeat (80) @(posedge pclk);
        ctl(`UART_CONTROL_REGISTER_RX_DIS);
      end
    join
    wait_rdy();
    apb(1'b0, `RECEIVE_HOLDING_REGISTER_OFS, 32'h0);
    `CHK("char finished", 8'h6c, rv[7:0])
    rx_one(3'h0, 8'h6d, 1'b0, 1'b1);
    `CHK("disabled idle", 1'b0, rx_req)
    $display("test rx control done");
    ctl(`UART_CONTROL_REGISTER_RX_EN);
    mode(3'h4, `DEBUG_UNIT_CHM_NORMAL);
    term.glitch(7);
    `CHK("short low ignored", 1'b0, rx_req)
    term.glitch(9);
    wait_rdy();
    apb(1'b0, `RECEIVE_HOLDING_REGISTER_OFS, 32'h0);
    `CHK("long low is start", 8'hff, rv[7:0])
    $display("test start detect done");
    ctl(`UART_CONTROL_REGISTER_TX_EN);
    apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
    `CHK("tx ready", 1'b1, rv[`UART_STATUS_REGISTER_TXRDY])
    `CHK("tx request", 1'b1, tx_req)
    mode(3'h4, `DEBUG_UNIT_CHM_LOCAL);
    apb(1'b1, `DEBUG_UNIT_THR_OFS, 32'ha7);
    wait_rdy();
    `CHK("rx request", 1'b1, rx_req)
    apb(1'b0, `RECEIVE_HOLDING_REGISTER_OFS, 32'h0);
    `CHK("local loop", 8'ha7, rv[7:0])
    mode(3'h4, `DEBUG_UNIT_CHM_NORMAL);
    fork
      term.get(d, ok);
      apb(1'b1, `DEBUG_UNIT_THR_OFS, 32'h3c);
    join
    `CHK("tx frame", 9'h13c, {ok, d})
    mode(3'h4, `DEBUG_UNIT_CHM_ECHO);
    fork
      term.get(d, ok);
      rx_one(3'h4, 8'h81, 1'b0, 1'b1);
    join
    `CHK("echo", 8'h81, d)
    mode(3'h4, `DEBUG_UNIT_CHM_REMOTE);
    fork
      term.get(d, ok);
      rx_one(3'h4, 8'h18, 1'b0, 1'b1);
    join
    `CHK("remote loop", 8'h18, d)
    $display("test channel modes done");
    apb(1'b1, `DEBUG_UNIT_EMU_OFS, 32'h1);
    `CHK("emu block", 1'b1, emu)
    {dcc_wr, dcc_rd} <= 2'b01;
    repeat (6) @(posedge pclk);
    apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
    `CHK("dcc read full", 3'b011, {rv[`UART_STATUS_REGISTER_DCC_WR], rv[`UART_STATUS_REGISTER_DCC_RD], irq})
    {dcc_wr, dcc_rd} <= 2'b10;
    repeat (6) @(posedge pclk);
    apb(1'b0, `DEBUG_UNIT_STAT_OFS, 32'h0);
    `CHK("dcc write full", 3'b101, {rv[`UART_STATUS_REGISTER_DCC_WR], rv[`UART_STATUS_REGISTER_DCC_RD], irq})
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped", 32'h0, rv)
    $display("test debug side done");
    complete_run();
  end
endmodule // tb_debug_unit_uart_receiver
